//--- spp_pkg.sv
// shared constants and types for the serial pin-level port
package spp_pkg;

  // word and bus geometry
  localparam int unsigned WORD_BITS = 8;          // bits per transferred word
  localparam int unsigned AW        = 8;          // wishbone byte address width
  localparam int unsigned DW        = 32;         // wishbone data width
  localparam logic [4:0]  LAST_EDGE = 5'h0F;      // 2 * WORD_BITS - 1 clock edges

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;        // serial_ctrl_reg
  localparam logic [7:0] OFF_TX   = 8'h04;        // transmit word, write starts master
  localparam logic [7:0] OFF_RX   = 8'h08;        // last received word
  localparam logic [7:0] OFF_STAT = 8'h0C;        // sticky events, write one to clear
  localparam logic [7:0] OFF_MASK = 8'h10;        // interrupt mask, same layout
  localparam logic [7:0] OFF_FLAG = 8'h14;        // general-purpose flag output

  // serial_ctrl_reg fields
  localparam int unsigned CTL_EN    = 0;          // port enable
  localparam int unsigned CTL_MSTR  = 1;          // 1 = master, 0 = slave
  localparam int unsigned CTL_CPOL  = 2;          // idle level of the bit clock
  localparam int unsigned CTL_CPHA  = 3;          // 1 = launch on leading edge
  localparam int unsigned CTL_OPD   = 4;          // open_drain_select
  localparam int unsigned CTL_SLAVE_OUT_DISABLE = 5;          // slave_out_disable
  localparam int unsigned CTL_DIV   = 8;          // lsb of half-period divider byte

  // status and mask fields
  localparam int unsigned ST_DONE = 0;            // word finished
  localparam int unsigned ST_MM   = 1;            // multimaster error
  localparam int unsigned ST_BUSY = 2;            // live, read only

  // reset values
  localparam logic [7:0]  DIV_RST  = 8'h07;       // half period = DIV + 1 clocks
  localparam logic [15:0] CTRL_RST = {DIV_RST, 8'h00};
  localparam logic        FLAG_RST = 1'b1;        // flag idles high (deselected)

  // shifter sequencing
  typedef enum logic {SPP_IDLE, SPP_RUN} spp_state_type;

endpackage : spp_pkg

//--- spp_link_if.sv
// serial link between the port and its far party, with pin resolution
`timescale 1ns/1ps
interface spp_link_if;
  // drives from the port
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic dev_flag_n;
  // drives from the far party
  logic peer_sclk_o;
  logic peer_sclk_oe;
  logic peer_mosi_o;
  logic peer_mosi_oe;
  logic peer_miso_o;
  logic peer_miso_oe;
  logic peer_ss_n_o;
  logic peer_ss_n_oe;
  // resolved wire levels, pull-ups where nobody drives
  logic sclk;
  logic mosi;
  logic miso;
  logic ss_n;
  logic peer_sel_n;

  assign sclk = dev_sclk_oe ? dev_sclk_o : (peer_sclk_oe ? peer_sclk_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b1);
  assign ss_n = peer_ss_n_oe ? peer_ss_n_o : 1'b1;
  // the port's flag output selects the far party as slave
  assign peer_sel_n = dev_flag_n;

  modport dev (output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
               output dev_miso_o, dev_miso_oe, dev_flag_n,
               input  sclk, mosi, miso, ss_n);
  modport peer (output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
                output peer_miso_o, peer_miso_oe, peer_ss_n_o, peer_ss_n_oe,
                input  sclk, mosi, miso, peer_sel_n);
endinterface : spp_link_if

//--- spp_shift.sv
// bit clock generator, slave edge finder and shift engine shared by both ends
`timescale 1ns/1ps
module spp_shift (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             en_i,
  input  wire logic                             master_i,
  input  wire logic                             cpol_i,
  input  wire logic                             cpha_i,
  input  wire logic [7:0]                       div_i,
  input  wire logic                             start_i,
  input  wire logic [spp_pkg::WORD_BITS-1:0]    tx_i,
  input  wire logic                             sclk_i,
  input  wire logic                             sel_n_i,
  input  wire logic                             din_i,
  output logic                                  sclk_o,
  output logic                                  dout_o,
  output logic                                  sel_o,
  output logic                                  sel_n_s_o,
  output logic                                  busy_o,
  output logic                                  done_o,
  output logic [spp_pkg::WORD_BITS-1:0]         rx_o
);
  import spp_pkg::*;

  logic [2:0]           f1_reg, f2_reg, f3_reg, s_reg;      // {sel_n, sclk, din} synchronisers
  logic [2:0]           f1_next, f2_next, f3_next, s_next;
  logic                 sp_reg, sp_next;                    // previous agreed bit clock
  spp_state_type        st_reg, st_next;                    // master sequencing
  logic [7:0]           hcnt_reg, hcnt_next;                // half-period counter
  logic [4:0]           ecnt_reg, ecnt_next;                // clock edges in this word
  logic                 sclk_reg, sclk_next;                // generated bit clock
  logic [WORD_BITS-1:0] sh_reg, sh_next;                    // transmit shifter
  logic [WORD_BITS-1:0] rsh_reg, rsh_next;                  // receive shifter
  logic [WORD_BITS-1:0] rx_reg, rx_next;                    // finished word
  logic                 done_reg, done_next;
  logic                 edge_ev;                            // one bit-clock edge now
  logic                 lead;                               // edge leaves idle level
  logic                 sel;                                // slave selected and enabled

  // slave is heard only while selected (active low) and enabled
  assign sel = en_i & ~master_i & ~s_reg[2];                // R4 R7

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    // three flops; the agreed level moves only when flops two and three agree
    f1_next   = {sel_n_i, sclk_i, din_i};
    f2_next   = f1_reg;
    f3_next   = f2_reg;
    s_next    = (f2_reg & f3_reg) | (s_reg & (f2_reg ^ f3_reg));
    sp_next   = s_reg[1];
    st_next   = st_reg;
    hcnt_next = hcnt_reg;
    ecnt_next = ecnt_reg;
    sclk_next = sclk_reg;
    sh_next   = sh_reg;
    rsh_next  = rsh_reg;
    rx_next   = rx_reg;
    done_next = 1'b0;
    edge_ev   = 1'b0;
    lead      = 1'b0;
    if (master_i)
    begin
      unique case (st_reg)
        SPP_IDLE:
        begin
          // clock rests at its idle level between words
          sclk_next = cpol_i;                               // R3
          hcnt_next = 8'h00;
          ecnt_next = 5'h00;
          if (start_i && en_i)
          begin
            st_next = SPP_RUN;
            sh_next = tx_i;
          end
        end
        SPP_RUN:
        begin
          if (!en_i)
          begin
            // abort: clock returns to idle, word is lost
            st_next = SPP_IDLE;
          end
          else if (hcnt_reg == div_i)
          begin
            // divider sets the bit rate; a slave's reply crosses both
            // synchronisers, about ten clocks, so keep the half period at ten
            // clocks or more or the master samples the previous bit
            hcnt_next = 8'h00;                              // R1
            sclk_next = ~sclk_reg;
            edge_ev   = 1'b1;
            lead      = (sclk_reg == cpol_i);
          end
          else
          begin
            hcnt_next = hcnt_reg + 8'h01;
          end
        end
      endcase
    end
    else
    begin
      st_next   = SPP_IDLE;
      sclk_next = cpol_i;
      if (!sel)
      begin
        // deselected: clock ignored, first bit preloaded for phase 0
        ecnt_next = 5'h00;                                  // R4
        sh_next   = tx_i;
      end
      else if (s_reg[1] != sp_reg)
      begin
        edge_ev = 1'b1;
        lead    = (s_reg[1] != cpol_i);
      end
    end
    // polarity and phase pick the launch and sample edges
    if (edge_ev)
    begin
      ecnt_next = ecnt_reg + 5'h01;
      if (lead ^ cpha_i)
      begin
        rsh_next = {rsh_reg[WORD_BITS-2:0], s_reg[0]};     // R5 R6
      end
      else if (ecnt_reg != 5'h00 && ecnt_reg != LAST_EDGE)
      begin
        sh_next = {sh_reg[WORD_BITS-2:0], 1'b0};            // R5 R6
      end
      // two edges per bit, so the word ends on the last edge
      if (ecnt_reg == LAST_EDGE)
      begin
        done_next = 1'b1;                                   // R2 R3
        rx_next   = rsh_next;
        st_next   = SPP_IDLE;
        ecnt_next = 5'h00;
        if (!master_i)
        begin
          sh_next = tx_i;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      f1_reg   <= 3'h7;
      f2_reg   <= 3'h7;
      f3_reg   <= 3'h7;
      s_reg    <= 3'h7;
      sp_reg   <= 1'b1;
      st_reg   <= SPP_IDLE;
      hcnt_reg <= 8'h00;
      ecnt_reg <= 5'h00;
      sclk_reg <= 1'b0;
      sh_reg   <= '0;
      rsh_reg  <= '0;
      rx_reg   <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      f1_reg   <= f1_next;
      f2_reg   <= f2_next;
      f3_reg   <= f3_next;
      s_reg    <= s_next;
      sp_reg   <= sp_next;
      st_reg   <= st_next;
      hcnt_reg <= hcnt_next;
      ecnt_reg <= ecnt_next;
      sclk_reg <= sclk_next;
      sh_reg   <= sh_next;
      rsh_reg  <= rsh_next;
      rx_reg   <= rx_next;
      done_reg <= done_next;
    end
  end

  assign sclk_o    = sclk_reg;
  assign dout_o    = sh_reg[WORD_BITS-1];
  assign sel_o     = sel;
  assign sel_n_s_o = s_reg[2];
  assign busy_o    = (st_reg == SPP_RUN) | (ecnt_reg != 5'h00);
  assign done_o    = done_reg;
  assign rx_o      = rx_reg;
endmodule : spp_shift

//--- spp_port.sv
// serial port end: wishbone registers, interrupt and pin drivers
//
// Notes on behaviour
// R1 - master makes bit clock; divider sets rate
// R2 - one bit clock cycle per data bit
// R3 - clock toggles only during a word
// R4 - slave ignores clock while select high
// R5 - launch on one edge, sample on other
// R6 - polarity and phase bits choose edges
// R7 - select is active low chip select
// R8 - select low while master: multimaster error
// R9 - flag output may select a slave
// R10 - mosi output as master, input as slave
// R11 - miso input as master, output as slave
// R12 - open-drain bit makes miso open drain
// R13 - only one slave drives miso
// R14 - control bit 5 disables miso output
// R15 - multimaster error: status flag, stop drivers
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module spp_port (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [spp_pkg::AW-1:0]       adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [spp_pkg::DW-1:0]       dat_i,
  output logic      [spp_pkg::DW-1:0]       dat_o,
  output logic                              ack_o,
  output logic                              irq_o,
  spp_link_if.dev                           link
);
  import spp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0]          ctrl_reg, ctrl_next;                // serial_ctrl_reg
  logic [WORD_BITS-1:0] tx_reg, tx_next;                    // word to send
  logic [1:0]           stat_reg, stat_next;                // sticky events
  logic [1:0]           mask_reg, mask_next;                // interrupt mask
  logic                 flag_reg, flag_next;                // gp flag, active low select
  logic                 ack_reg, ack_next;                  // bus acknowledge
  logic [DW-1:0]        dat_reg, dat_next;                  // read data
  logic                 start_reg, start_next;              // master start pulse

  // engine wiring
  logic                 eng_sclk;
  logic                 eng_dout;
  logic                 eng_sel;
  logic                 eng_sel_n_s;
  logic                 eng_busy;
  logic                 eng_done;
  logic [WORD_BITS-1:0] eng_rx;

  // decoded control
  logic                 en;
  logic                 master;
  logic                 drv;                                // allowed to drive pins
  logic                 slave_out;                          // slave owns miso now
  logic                 mm_set;                             // multimaster event
  logic                 acc;                                // bus cycle present
  logic                 wr;                                 // write commits this edge
  logic [1:0]           clr;                                // write-one-to-clear mask

  assign en     = ctrl_reg[CTL_EN];
  assign master = ctrl_reg[CTL_MSTR];
  // an error halts the port until software clears the flag
  assign drv    = en & ~stat_reg[ST_MM];                    // R15
  // select low while master means another master is on the bus
  assign mm_set = en & master & ~eng_sel_n_s;               // R8

  //////////////////////////////////////////////////////////////////////////////
  // shift engine; while halted it also aborts a running master word
  spp_shift u_shift (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (drv),
    .master_i  (master),
    .cpol_i    (ctrl_reg[CTL_CPOL]),
    .cpha_i    (ctrl_reg[CTL_CPHA]),
    .div_i     (ctrl_reg[CTL_DIV+7:CTL_DIV]),
    .start_i   (start_reg),
    .tx_i      (tx_reg),
    .sclk_i    (link.sclk),
    .sel_n_i   (link.ss_n),
    .din_i     (master ? link.miso : link.mosi),
    .sclk_o    (eng_sclk),
    .dout_o    (eng_dout),
    .sel_o     (eng_sel),
    .sel_n_s_o (eng_sel_n_s),
    .busy_o    (eng_busy),
    .done_o    (eng_done),
    .rx_o      (eng_rx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register file and bus slave, next values
  always_comb
  begin
    acc        = cyc_i & stb_i;
    // write lands on the edge where the master sees ack
    wr         = acc & we_i & ack_reg;
    ack_next   = acc & ~ack_reg;
    dat_next   = dat_reg;
    ctrl_next  = ctrl_reg;
    tx_next    = tx_reg;
    mask_next  = mask_reg;
    flag_next  = flag_reg;
    start_next = 1'b0;
    clr        = 2'h0;
    if (acc && !ack_reg)
    begin
      // read data is staged with ack; unmapped reads give zero
      unique case (adr_i)
        OFF_CTRL: dat_next = {16'h0000, ctrl_reg};
        OFF_TX:   dat_next = {24'h000000, tx_reg};
        OFF_RX:   dat_next = {24'h000000, eng_rx};
        OFF_STAT: dat_next = {29'h00000000, eng_busy, stat_reg};
        OFF_MASK: dat_next = {30'h00000000, mask_reg};
        OFF_FLAG: dat_next = {31'h00000000, flag_reg};
        default:  dat_next = 32'h00000000;
      endcase
    end
    if (wr)
    begin
      // unmapped writes are acknowledged and dropped
      unique case (adr_i)
        OFF_CTRL:
        begin
          if (sel_i[0])
          begin
            ctrl_next[7:0] = dat_i[7:0];                    // R6 R12 R14
          end
          if (sel_i[1])
          begin
            ctrl_next[15:8] = dat_i[15:8];                  // R1
          end
        end
        OFF_TX:
        begin
          if (sel_i[0])
          begin
            tx_next    = dat_i[7:0];
            // a write while busy only updates the next slave word
            start_next = master & ~eng_busy;
          end
        end
        OFF_STAT:
        begin
          if (sel_i[0])
          begin
            clr = dat_i[1:0];
          end
        end
        OFF_MASK:
        begin
          if (sel_i[0])
          begin
            mask_next = dat_i[1:0];
          end
        end
        OFF_FLAG:
        begin
          if (sel_i[0])
          begin
            flag_next = dat_i[0];                           // R9
          end
        end
        default:
        begin
          clr = 2'h0;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    stat_next = (stat_reg & ~clr) | {mm_set, eng_done};     // R15
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file and bus slave, flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg  <= CTRL_RST;
      tx_reg    <= '0;
      stat_reg  <= 2'h0;
      mask_reg  <= 2'h0;
      flag_reg  <= FLAG_RST;
      ack_reg   <= 1'b0;
      dat_reg   <= '0;
      start_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      tx_reg    <= tx_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      flag_reg  <= flag_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      start_reg <= start_next;
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  // level interrupt while any unmasked event is pending
  assign irq_o = |(stat_reg & mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers
  // master owns clock and mosi; released entirely on an error
  assign link.dev_sclk_o  = eng_sclk;                       // R1
  assign link.dev_sclk_oe = drv & master;                   // R1 R15
  assign link.dev_mosi_o  = eng_dout;                       // R10
  assign link.dev_mosi_oe = drv & master;                   // R10 R15
  // slave drives miso only while selected, so a deselected slave never
  // fights the one in use; the disable bit silences it for broadcast
  assign slave_out = drv & ~master & eng_sel & ~ctrl_reg[CTL_SLAVE_OUT_DISABLE]; // R11 R13 R14
  // open drain pulls low only; a one is left to the pull-up
  assign link.dev_miso_oe = slave_out & (~ctrl_reg[CTL_OPD] | ~eng_dout); // R12
  assign link.dev_miso_o  = ctrl_reg[CTL_OPD] ? 1'b0 : eng_dout;         // R11 R12
  assign link.dev_flag_n  = flag_reg;                       // R9
endmodule : spp_port

//--- spp_peer.sv
// far party: a plain serial master or slave driven from user ports
`timescale 1ns/1ps
module spp_peer (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  spp_link_if.peer                              link,
  input  wire logic                             master_i,
  input  wire logic                             cpol_i,
  input  wire logic                             cpha_i,
  input  wire logic [7:0]                       div_i,
  input  wire logic                             start_i,
  input  wire logic [spp_pkg::WORD_BITS-1:0]    tx_i,
  input  wire logic                             assert_sel_i,
  output logic [spp_pkg::WORD_BITS-1:0]         rx_o,
  output logic                                  done_o,
  output logic                                  busy_o
);
  import spp_pkg::*;

  logic eng_sclk;                                           // generated clock
  logic eng_dout;                                           // outgoing bit
  logic eng_sel;                                            // selected as slave

  //////////////////////////////////////////////////////////////////////////////
  // same engine as the port; as master its select input is held inactive
  spp_shift u_shift (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (1'b1),
    .master_i  (master_i),
    .cpol_i    (cpol_i),
    .cpha_i    (cpha_i),
    .div_i     (div_i),
    .start_i   (start_i),
    .tx_i      (tx_i),
    .sclk_i    (link.sclk),
    .sel_n_i   (master_i ? 1'b1 : link.peer_sel_n),
    .din_i     (master_i ? link.miso : link.mosi),
    .sclk_o    (eng_sclk),
    .dout_o    (eng_dout),
    .sel_o     (eng_sel),
    .sel_n_s_o (),
    .busy_o    (busy_o),
    .done_o    (done_o),
    .rx_o      (rx_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pins: master drives clock, mosi and the port's select; slave drives miso
  assign link.peer_sclk_o  = eng_sclk;                      // R1
  assign link.peer_sclk_oe = master_i;
  assign link.peer_mosi_o  = eng_dout;
  assign link.peer_mosi_oe = master_i;
  assign link.peer_miso_o  = eng_dout;
  assign link.peer_miso_oe = ~master_i & eng_sel;           // R13
  assign link.peer_ss_n_o  = 1'b0;                          // R7
  assign link.peer_ss_n_oe = master_i & assert_sel_i;
endmodule : spp_peer

//--- spp_link_chk.sv
// checker on the link: pin directions, selection and multimaster back-off
`timescale 1ns/1ps
module spp_link_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic dev_flag_n,
  input wire logic peer_sclk_oe,
  input wire logic peer_mosi_oe,
  input wire logic peer_miso_oe,
  input wire logic ss_n
);
  // one clock domain, so clocking and disable are set once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($fell(rst_i) |-> !dev_sclk_oe && !dev_miso_oe && dev_flag_n)
    else $error("port drives a pin after reset");
  a_miso_single: assert property (!(dev_miso_oe && peer_miso_oe))
    else $error("two drivers on slave data line");
  a_master_dirs: assert property (dev_sclk_oe |-> dev_mosi_oe && !dev_miso_oe)
    else $error("master pin directions wrong");
  a_slave_dirs: assert property (dev_miso_oe |-> !dev_mosi_oe && !dev_sclk_oe)
    else $error("slave pin directions wrong");
  // six cycles leave room for the select synchroniser
  a_desel_quiet: assert property (ss_n [*6] |-> !dev_miso_oe)
    else $error("deselected slave drives data");
  a_mm_backoff: assert property ($fell(ss_n) && dev_sclk_oe |-> ##[1:6] !dev_sclk_oe)
    else $error("master kept clock after select fell");
  a_mm_hold: assert property (!ss_n [*6] |-> !dev_sclk_oe && !dev_mosi_oe)
    else $error("port drives while select is low");
  a_peer_dirs: assert property (peer_sclk_oe |-> peer_mosi_oe && !peer_miso_oe)
    else $error("far master pin directions wrong");
endmodule : spp_link_chk

//--- tb_spp_pin_level_port.sv
// bench: port and far party joined over the link, driven through wishbone
`timescale 1ns/1ps
module tb_spp_pin_level_port;
  import spp_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic        p_m = 0, p_cpol = 0, p_cpha = 0, p_go = 0, p_sel = 0, p_done, p_busy;
  logic        sclk_d = 1, od_on = 0;
  logic [7:0]  adr = 0, p_tx = 0, p_rx;
  logic [31:0] wdat = 0, rd, q;
  logic [7:0]  ptx [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E}; // port words, one row per mode
  logic [7:0]  qtx [4] = '{8'h5A, 8'hC3, 8'h18, 8'hE7}; // far words
  int          n_fail = 0, tests_run = 0, n_edge = 0, base, k;
  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  spp_link_if i_spp_link_if ();
  spp_port i_spp_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rd), .ack_o(ack), .irq_o(irq),
    .link(i_spp_link_if));
  spp_peer i_spp_peer (.clk_i(clk_i), .rst_i(rst_i), .link(i_spp_link_if), .master_i(p_m),
    .cpol_i(p_cpol), .cpha_i(p_cpha), .div_i(8'h0B), .start_i(p_go), .tx_i(p_tx),
    .assert_sel_i(p_sel), .rx_o(p_rx), .done_o(p_done), .busy_o(p_busy));
  spp_link_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .dev_sclk_oe(i_spp_link_if.dev_sclk_oe),
    .dev_mosi_oe(i_spp_link_if.dev_mosi_oe), .dev_miso_oe(i_spp_link_if.dev_miso_oe),
    .dev_flag_n(i_spp_link_if.dev_flag_n), .peer_sclk_oe(i_spp_link_if.peer_sclk_oe),
    .peer_mosi_oe(i_spp_link_if.peer_mosi_oe), .peer_miso_oe(i_spp_link_if.peer_miso_oe),
    .ss_n(i_spp_link_if.ss_n));
  ////////////////////////////////////////////////////////////////////////////////
  // counts every change of the resolved bit clock
  always @(posedge clk_i)
  begin
    sclk_d <= i_spp_link_if.sclk;
    if (i_spp_link_if.sclk !== sclk_d) n_edge <= n_edge + 1;
  end
  // open drain may only pull low
  always @(negedge clk_i)
    if (od_on && i_spp_link_if.dev_miso_oe === 1'b1) chk(i_spp_link_if.dev_miso_o, 0);
  task conclude();
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; ack and read data are taken at the rising edge, then released
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task wait_st(input logic [31:0] m);
    for (int j = 0; j < 100 && (q & m) === 0; j++) wb(0, 8'h0C, 0);
    if ((q & m) === 0) n_fail++;
  endtask : wait_st
  // far party masters one word at the port acting as slave
  task sx(input logic [31:0] ctl, input logic s, input logic [7:0] pt, input logic [7:0] qt);
    wb(1, 8'h00, ctl);
    wb(1, 8'h04, {24'h0, pt});
    {p_m, p_tx} <= {1'b1, qt};
    // clock settles at idle before select falls, so no false edge is counted
    repeat (6) @(posedge clk_i);
    p_sel <= s;
    repeat (6) @(posedge clk_i);
    p_go <= 1;
    @(posedge clk_i);
    p_go <= 0;
    for (int j = 0; j < 300 && p_done !== 1'b1; j++) @(posedge clk_i);
    if (p_done !== 1'b1) n_fail++;
    repeat (8) @(posedge clk_i);
    p_sel <= 0;
  endtask : sx
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0); chk(q, 32'h0700);
    wb(0, 8'h14, 0); chk(q, 1);
    wb(0, 8'h20, 0); chk(q, 0);
    wb(1, 8'h10, 1);
    // every polarity and phase, port as master
    for (int i = 0; i < 4; i++)
    begin
      {p_cpol, p_cpha, p_tx} <= {i[1], i[0], qtx[i]};
      wb(1, 8'h00, {16'h0, 8'h0B, 4'h0, i[0], i[1], 2'h3});
      wb(1, 8'h14, 0);
      base = n_edge;
      wb(1, 8'h04, {24'h0, ptx[i]});
      q = 0;
      wait_st(1);
      chk(n_edge - base, 16);
      chk(irq, 1);
      wb(0, 8'h08, 0); chk(q, qtx[i]);
      chk(p_rx, ptx[i]);
      wb(1, 8'h0C, 1);
      @(negedge clk_i) chk(irq, 0);
      wb(1, 8'h14, 1);
    end
    {p_cpol, p_cpha} <= 2'b00;
    sx(32'h0301, 1, 8'hC6, 8'h39);
    chk(p_rx, 8'hC6);
    chk(p_busy, 0);
    wb(0, 8'h08, 0); chk(q, 8'h39);
    wb(1, 8'h0C, 1);
    sx(32'h0301, 0, 8'h5A, 8'hA5);
    chk(p_rx, 8'hFF);
    wb(0, 8'h0C, 0); chk(q[0], 0);
    sx(32'h0321, 1, 8'h5A, 8'h66);
    chk(p_rx, 8'hFF);
    wb(0, 8'h08, 0); chk(q, 8'h66);
    od_on = 1;
    sx(32'h0311, 1, 8'h96, 8'h00);
    chk(p_rx, 8'h96);
    od_on = 0;
    // second master pulls the select low while the port is master
    p_m <= 0;
    wb(1, 8'h0C, 3);
    wb(1, 8'h00, 32'h0303);
    {p_m, p_sel} <= 2'b11;
    repeat (10) @(posedge clk_i);
    wb(0, 8'h0C, 0); chk(q[1], 1);
    chk(i_spp_link_if.dev_sclk_oe, 0);
    @(negedge clk_i) chk(irq, 0);
    wb(1, 8'h10, 2);
    @(negedge clk_i) chk(irq, 1);
    wb(1, 8'h04, 8'h11);
    wb(0, 8'h0C, 0); chk(q[2], 0);
    {p_m, p_sel} <= 2'b00;
    repeat (8) @(posedge clk_i);
    wb(1, 8'h0C, 2);
    @(negedge clk_i) chk(irq, 0);
    wb(0, 8'h0C, 0); chk(q[1], 0);
    conclude();
  end
endmodule : tb_spp_pin_level_port
